/* src/alb_top.sv */
// Alarm log unit: active buffer, history, counter and status bit
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "alb_consts.svh"

module alb_top (
    input wire logic aclk, // System clock, 250 MHz
    input wire logic aresetn, // Synchronous reset, low active
    input wire logic [7:0] s_axil_awaddr, // Write address
    input wire logic s_axil_awvalid, // Write address valid
    output logic s_axil_awready, // Write address ready
    input wire logic [31:0] s_axil_wdata, // Write data
    input wire logic [3:0] s_axil_wstrb, // Write byte strobes
    input wire logic s_axil_wvalid, // Write data valid
    output logic s_axil_wready, // Write data ready
    output logic [1:0] s_axil_bresp, // Write response
    output logic s_axil_bvalid, // Write response valid
    input wire logic s_axil_bready, // Write response ready
    input wire logic [7:0] s_axil_araddr, // Read address
    input wire logic s_axil_arvalid, // Read address valid
    output logic s_axil_arready, // Read address ready
    output logic [31:0] s_axil_rdata, // Read data
    output logic [1:0] s_axil_rresp, // Read response
    output logic s_axil_rvalid, // Read data valid
    input wire logic s_axil_rready, // Read data ready
    input wire logic alarm_raise, // Pulse: a new alarm arrives
    input wire logic [15:0] alarm_code_in, // Code of arriving alarm
    input wire logic [31:0] alarm_fixed_in, // Fixed-point value of arriving alarm
    input wire logic [31:0] alarm_float_in, // Float value of arriving alarm
    input wire logic alarm_gone, // Pulse: cause of an alarm disappeared
    input wire logic [15:0] alarm_gone_code, // Code whose cause disappeared
    input wire logic [15:0] sys_days, // Time base, whole days
    input wire logic [31:0] sys_ms, // Time base, ms within the day
    output logic [15:0] drive_status_word_one, // Status word one
    output logic [15:0] latest_alarm_code // Code of the newest alarm
);

    alb_pkg::alb_log_t log_reg, log_next; // 8 buffer slots plus 56 history slots
    logic [31:0] cnt_reg, cnt_next;
    logic [15:0] latest_reg, latest_next;
    logic [15:0] status_reg, status_next;
    logic [5:0] index_reg, index_next;
    logic [3:0] slot_w;
    logic wr_en, wr_err, rd_err;
    logic [7:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data, cnt_merged, index_merged;
    logic [3:0] wr_strb;
    logic cnt_wr, cnt_zero_wr;
    alb_pkg::alb_entry_t view;

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Byte-strobe merge of a register write
    function automatic logic [31:0] alb_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        return r;
    endfunction : alb_merge

    // Any address not in the map gets an error answer
    function automatic logic alb_unmapped(input logic [7:0] a);
        return (a[1:0] != 2'h0) || (a > `ALB_FLAGS_OFS);
    endfunction : alb_unmapped

    // Occupied buffer slots; the buffer is always packed from slot 0
    function automatic logic [3:0] alb_count_valid(input alb_pkg::alb_log_t l);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < `ALB_BUF_DEPTH; i++)
            if (l[i].valid)
                n = n + 4'h1;
        return n;
    endfunction : alb_count_valid

    function automatic logic alb_any_removed(input alb_pkg::alb_log_t l);
        logic r;
        r = 1'b0;
        for (int i = 0; i < `ALB_BUF_DEPTH; i++)
            r = r | (l[i].valid & l[i].removed);
        return r;
    endfunction : alb_any_removed

    // Move removed buffer alarms into history, newest first, then pack the rest
    function automatic alb_pkg::alb_log_t alb_flush(input alb_pkg::alb_log_t l);
        alb_pkg::alb_log_t r;
        int n;
        int k;
        int a;
        r = l;
        n = 0;
        for (int i = 0; i < `ALB_BUF_DEPTH; i++)
            if (l[i].valid && l[i].removed)
                n++;
        // Old history slides up by n; entries pushed past 63 fall off
        for (int j = `ALB_HIST_FIRST; j <= `ALB_LOG_LAST; j++)
            r[j] = (j - n >= `ALB_HIST_FIRST) ? l[j - n] : '0;
        // Youngest removed alarm lands at index 8
        k = `ALB_HIST_FIRST;
        for (int i = `ALB_BUF_DEPTH - 1; i >= 0; i--)
            if (l[i].valid && l[i].removed) // Only removed alarms go
            begin
                r[k] = l[i];
                k++;
            end
        // Still-active alarms closed up in arrival order
        for (int i = 0; i < `ALB_BUF_DEPTH; i++)
            r[i] = '0;
        a = 0;
        for (int i = 0; i < `ALB_BUF_DEPTH; i++)
            if (l[i].valid && !l[i].removed)
            begin
                r[a] = l[i];
                a++;
            end
        return r;
    endfunction : alb_flush

    ////////////////////////////////////////////////////////////////////////////
    // Bus front end
    alb_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // Write decode; a zero landing in the counter also moves removed buffer alarms to history
    assign wr_err = alb_unmapped(wr_addr);
    assign cnt_merged = alb_merge(cnt_reg, wr_data, wr_strb);
    assign index_merged = alb_merge({26'h0000000, index_reg}, wr_data, wr_strb);
    assign cnt_wr = wr_en && (wr_addr == `ALB_CNT_OFS);
    assign cnt_zero_wr = cnt_wr && (cnt_merged == 32'h00000000);
    assign view = log_reg[index_reg];

    // Read decode through the selected log index
    always_comb
    begin
        rd_err = alb_unmapped(rd_addr);
        rd_data = 32'h00000000;
        if (rd_addr == `ALB_CNT_OFS)
            rd_data = cnt_reg;
        else if (rd_addr == `ALB_LATEST_OFS)
            rd_data = {16'h0000, latest_reg};
        else if (rd_addr == `ALB_STATUS_OFS)
            rd_data = {16'h0000, status_reg};
        else if (rd_addr == `ALB_INDEX_OFS)
            rd_data = {26'h0000000, index_reg};
        else if (rd_addr == `ALB_CODE_OFS)
            rd_data = {16'h0000, view.code};
        else if (rd_addr == `ALB_FIXED_OFS)
            rd_data = view.fixed;
        else if (rd_addr == `ALB_FLOAT_OFS)
            rd_data = view.float_val;
        else if (rd_addr == `ALB_ARR_DAYS_OFS)
            rd_data = {16'h0000, view.arr_days};
        else if (rd_addr == `ALB_ARR_MS_OFS)
            rd_data = view.arr_ms;
        else if (rd_addr == `ALB_REM_DAYS_OFS)
            rd_data = {16'h0000, view.rem_days};
        else if (rd_addr == `ALB_REM_MS_OFS)
            rd_data = view.rem_ms;
        else if (rd_addr == `ALB_FLAGS_OFS)
            rd_data = {30'h00000000, view.removed, view.valid};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Log update: removals first, then a counter flush, then the arrival.
    // Doing removal first means an alarm that goes and returns in one cycle
    // is logged twice, which keeps the new arrival from being lost.
    always_comb
    begin
        log_next = log_reg;
        slot_w = 4'h0;
        for (int i = 0; i < `ALB_BUF_DEPTH; i++)
            if (alarm_gone && log_reg[i].valid && !log_reg[i].removed
                && log_reg[i].code == alarm_gone_code)
            begin
                // Entry is kept, only stamped
                log_next[i].removed = 1'b1;
                log_next[i].rem_days = sys_days;
                log_next[i].rem_ms = sys_ms;
            end
        if (cnt_zero_wr)
            log_next = alb_flush(log_next);
        if (alarm_raise)
        begin
            if (alb_count_valid(log_next) == 4'(`ALB_BUF_DEPTH)
                && alb_any_removed(log_next))
                log_next = alb_flush(log_next);
            slot_w = alb_count_valid(log_next); // Lowest free slot
            if (slot_w == 4'(`ALB_BUF_DEPTH))
                slot_w = {1'b0, `ALB_OVERWRITE_SLOT};
            // Code, both value forms, arrival stamp; removal left zero
            log_next[slot_w[2:0]].valid = 1'b1;
            log_next[slot_w[2:0]].removed = 1'b0;
            log_next[slot_w[2:0]].code = alarm_code_in;
            log_next[slot_w[2:0]].fixed = alarm_fixed_in;
            log_next[slot_w[2:0]].float_val = alarm_float_in;
            log_next[slot_w[2:0]].arr_days = sys_days;
            log_next[slot_w[2:0]].arr_ms = sys_ms;
            log_next[slot_w[2:0]].rem_days = 16'h0000;
            log_next[slot_w[2:0]].rem_ms = 32'h00000000;
        end
    end

    // Counter, latest code, status and index next values
    always_comb
    begin
        cnt_next = (cnt_wr ? cnt_merged : cnt_reg) + {31'h00000000, alarm_raise};
        latest_next = alarm_raise ? alarm_code_in : latest_reg;
        status_next = 16'h0000;
        for (int i = 0; i < `ALB_BUF_DEPTH; i++)
            if (log_next[i].valid && !log_next[i].removed)
                status_next[`ALB_PRESENT_BIT] = 1'b1;
        index_next = index_reg;
        if (wr_en && wr_addr == `ALB_INDEX_OFS)
            index_next = index_merged[5:0]; // Only six bits address the 64 entries
    end

    // Register stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            log_reg <= '0;
            cnt_reg <= `ALB_CNT_RST;
            latest_reg <= 16'h0000;
            status_reg <= 16'h0000;
            index_reg <= `ALB_INDEX_RST;
        end
        else
        begin
            log_reg <= log_next;
            cnt_reg <= cnt_next;
            latest_reg <= latest_next;
            status_reg <= status_next;
            index_reg <= index_next;
        end
    end

    assign drive_status_word_one = status_reg;
    assign latest_alarm_code = latest_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic hist_ok, rem_empty_ok, packed_ok;

    // Whole-array invariants watched every cycle
    always_comb
    begin
        hist_ok = 1'b1;
        rem_empty_ok = 1'b1;
        packed_ok = 1'b1;
        for (int j = `ALB_HIST_FIRST; j <= `ALB_LOG_LAST; j++)
            if (log_reg[j].valid && !log_reg[j].removed)
                hist_ok = 1'b0;
        for (int i = 0; i < `ALB_BUF_DEPTH; i++)
            if (log_reg[i].valid && !log_reg[i].removed
                && (log_reg[i].rem_days != 16'h0000 || log_reg[i].rem_ms != 32'h00000000))
                rem_empty_ok = 1'b0;
        for (int i = 1; i < `ALB_BUF_DEPTH; i++)
            if (log_reg[i].valid && !log_reg[i - 1].valid)
                packed_ok = 1'b0;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence raise_only_s;
        alarm_raise && !alarm_gone && !cnt_wr;
    endsequence

    sequence flush_only_s;
        cnt_zero_wr && !alarm_raise && !alarm_gone;
    endsequence

    count_incr_a: assert property (raise_only_s |=> cnt_reg == $past(cnt_reg) + 32'h1)
        else $error("alarm counter did not step");
    latest_code_a: assert property (alarm_raise |=> latest_reg == $past(alarm_code_in))
        else $error("latest code not updated");
    present_bit_a: assert property (alarm_raise |=> drive_status_word_one[7])
        else $error("present bit low after alarm");
    overwrite_slot_a: assert property (
        raise_only_s ##0 (alb_count_valid(log_reg) == 4'h8 && !alb_any_removed(log_reg))
        |=> log_reg[6].code == $past(alarm_code_in) && log_reg[7].code == $past(log_reg[7].code))
        else $error("full buffer not overwritten at slot six");
    removal_stamp_a: assert property (
        alarm_gone && !alarm_raise && !cnt_wr && log_reg[0].valid && !log_reg[0].removed
        && log_reg[0].code == alarm_gone_code
        |=> log_reg[0].valid && log_reg[0].removed && log_reg[0].rem_ms == $past(sys_ms)
        && log_reg[0].rem_days == $past(sys_days))
        else $error("removal time not stamped");
    newest_first_a: assert property (
        flush_only_s ##0 (log_reg[7].valid && log_reg[7].removed)
        |=> log_reg[8].code == $past(log_reg[7].code) && !log_reg[7].valid)
        else $error("youngest removed alarm not at index eight");
    flush_clean_a: assert property (flush_only_s |=> !alb_any_removed(log_reg) ##1 packed_ok)
        else $error("removed alarms left after counter zero");
    hist_removed_a: assert property (hist_ok)
        else $error("active alarm found in history");
    rem_empty_a: assert property (rem_empty_ok)
        else $error("active alarm has removal time");
    packed_buf_a: assert property (packed_ok)
        else $error("gap in active buffer");

endmodule : alb_top
`default_nettype wire

/* src/alb_consts.svh */
// Offsets, field positions, reset values and sizes of the alarm log unit
// How it works
// - Alarms self-clear when their cause goes; no acknowledge and no effect on control.
// - Status word one bit 7 is high while any alarm is active.
// - Each incoming alarm stores its code, value and arrival time.
// - Alarm value is stored twice: fixed-point copy and floating-point copy.
// - Timestamps are whole days plus milliseconds within the day, from the time base.
// - When the cause disappears, removal days and milliseconds go into the entry.
// - A removed alarm stays in the active buffer.
// - Further alarms are stored beside earlier ones; a counter counts alarms since reset.
// - Eight buffer slots; ninth alarm with none removed overwrites slot six.
// - History holds 56 entries.
// - Full buffer plus new alarm moves removed alarms to history; only removed ones.
// - History is newest first, youngest at index 8, next at 9.
// - After the move, still-active alarms are packed together without gaps.
// - With history full to 63, each new history entry drops the oldest.
// - Writing zero to the alarm counter moves removed buffer alarms to history.
// - A readable code always shows the most recently arrived alarm.
`ifndef ALB_CONSTS_SVH
`define ALB_CONSTS_SVH

// Register byte offsets
`define ALB_CNT_OFS 8'h00
`define ALB_LATEST_OFS 8'h04
`define ALB_STATUS_OFS 8'h08
`define ALB_INDEX_OFS 8'h0C
`define ALB_CODE_OFS 8'h10
`define ALB_FIXED_OFS 8'h14
`define ALB_FLOAT_OFS 8'h18
`define ALB_ARR_DAYS_OFS 8'h1C
`define ALB_ARR_MS_OFS 8'h20
`define ALB_REM_DAYS_OFS 8'h24
`define ALB_REM_MS_OFS 8'h28
`define ALB_FLAGS_OFS 8'h2C

// Field positions and sizes
`define ALB_PRESENT_BIT 7
`define ALB_BUF_DEPTH 8
`define ALB_HIST_FIRST 8
`define ALB_LOG_LAST 63
`define ALB_OVERWRITE_SLOT 3'h6

// Reset values and bus answers
`define ALB_CNT_RST 32'h00000000
`define ALB_INDEX_RST 6'h00
`define ALB_RESP_OKAY 2'h0
`define ALB_RESP_SLVERR 2'h2

`endif

/* src/alb_pkg.sv */
// Types shared by the alarm log unit
package alb_pkg;

    // One log entry; removal fields stay zero while the alarm is active
    typedef struct packed {
        logic valid;
        logic removed;
        logic [15:0] code;
        logic [31:0] fixed;
        logic [31:0] float_val;
        logic [15:0] arr_days;
        logic [31:0] arr_ms;
        logic [15:0] rem_days;
        logic [31:0] rem_ms;
    } alb_entry_t;

    // Slots 0..7 active buffer, 8..63 history
    typedef alb_entry_t [63:0] alb_log_t;

endpackage : alb_pkg

/* src/alb_axil_slave.sv */
// AXI4-Lite slave front end: turns bus beats into one-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
`include "alb_consts.svh"

module alb_axil_slave (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, low active
    input wire logic [7:0] s_axil_awaddr, // Write address
    input wire logic s_axil_awvalid, // Write address valid
    output logic s_axil_awready, // Write address ready
    input wire logic [31:0] s_axil_wdata, // Write data
    input wire logic [3:0] s_axil_wstrb, // Write byte strobes
    input wire logic s_axil_wvalid, // Write data valid
    output logic s_axil_wready, // Write data ready
    output logic [1:0] s_axil_bresp, // Write response
    output logic s_axil_bvalid, // Write response valid
    input wire logic s_axil_bready, // Write response ready
    input wire logic [7:0] s_axil_araddr, // Read address
    input wire logic s_axil_arvalid, // Read address valid
    output logic s_axil_arready, // Read address ready
    output logic [31:0] s_axil_rdata, // Read data
    output logic [1:0] s_axil_rresp, // Read response
    output logic s_axil_rvalid, // Read data valid
    input wire logic s_axil_rready, // Read data ready
    output logic wr_en, // One-cycle register write strobe
    output logic [7:0] wr_addr, // Register write address
    output logic [31:0] wr_data, // Register write data
    output logic [3:0] wr_strb, // Register write strobes
    input wire logic wr_err, // Write address unmapped
    output logic [7:0] rd_addr, // Register read address
    input wire logic [31:0] rd_data, // Register read data
    input wire logic rd_err // Read address unmapped
);

    logic aw_held_reg, aw_held_next;
    logic w_held_reg, w_held_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    ////////////////////////////////////////////////////////////////////////////
    // Address and data are caught in either order; nothing new is taken while
    // a response waits, so one write is in flight at most
    assign s_axil_awready = !aw_held_reg && !bvalid_reg;
    assign s_axil_wready = !w_held_reg && !bvalid_reg;
    assign s_axil_arready = !rvalid_reg;
    assign wr_en = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_addr = awaddr_reg;
    assign wr_data = wdata_reg;
    assign wr_strb = wstrb_reg;
    assign rd_addr = s_axil_araddr;
    assign s_axil_bvalid = bvalid_reg;
    assign s_axil_bresp = bresp_reg;
    assign s_axil_rvalid = rvalid_reg;
    assign s_axil_rdata = rdata_reg;
    assign s_axil_rresp = rresp_reg;

    // Next state of both channels
    always_comb
    begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axil_awvalid && s_axil_awready)
        begin
            aw_held_next = 1'b1;
            awaddr_next = s_axil_awaddr;
        end
        if (s_axil_wvalid && s_axil_wready)
        begin
            w_held_next = 1'b1;
            wdata_next = s_axil_wdata;
            wstrb_next = s_axil_wstrb;
        end
        if (wr_en)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_err ? `ALB_RESP_SLVERR : `ALB_RESP_OKAY;
        end
        else if (bvalid_reg && s_axil_bready)
        begin
            bvalid_next = 1'b0;
        end
        if (s_axil_arvalid && s_axil_arready)
        begin
            rvalid_next = 1'b1;
            rdata_next = rd_err ? 32'h00000000 : rd_data;
            rresp_next = rd_err ? `ALB_RESP_SLVERR : `ALB_RESP_OKAY;
        end
        else if (rvalid_reg && s_axil_rready)
        begin
            rvalid_next = 1'b0;
        end
    end

    // Register stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `ALB_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `ALB_RESP_OKAY;
        end
        else
        begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

endmodule : alb_axil_slave
`default_nettype wire

/* test/alarm_log_buffer_bench.sv */
// Self-checking bench for the alarm log unit
`timescale 1ns/1ps
`default_nettype none
`include "alb_consts.svh"
module alarm_log_buffer_bench;
    typedef struct packed {logic [15:0] c; logic [31:0] fx; logic [31:0] fl; logic [31:0] n;} alb_row_t;
    alb_row_t rows [8];
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, rise = 0, gone = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [15:0] c = 0, days = 0, k, stat, lat;
    logic [31:0] wd = 0, fx = 0, fl = 0, ms = 0, d, rdat;
    logic [1:0] r, b, br, rr;
    logic awr, wry, bv, arr, rv;
    int fail_count = 0, n_tests = 0;
    ////////////////////////////////////////////////////////////////////////
    // Unit under test; byte strobes stay full since every word is whole
    alb_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awa), .s_axil_awvalid(awv),
        .s_axil_awready(awr), .s_axil_wdata(wd), .s_axil_wstrb(4'hF), .s_axil_wvalid(wv),
        .s_axil_wready(wry), .s_axil_bresp(br), .s_axil_bvalid(bv), .s_axil_bready(bry),
        .s_axil_araddr(ara), .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_rdata(rdat),
        .s_axil_rresp(rr), .s_axil_rvalid(rv), .s_axil_rready(rry), .alarm_raise(rise),
        .alarm_code_in(c), .alarm_fixed_in(fx), .alarm_float_in(fl), .alarm_gone(gone),
        .alarm_gone_code(c), .sys_days(days), .sys_ms(ms), .drive_status_word_one(stat),
        .latest_alarm_code(lat));
    ////////////////////////////////////////////////////////////////////////
    // Clock at 4 ns
    initial
    begin
        forever #2 aclk = ~aclk;
    end
    // Value compare, counted
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Write beat; each channel dropped only at its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        {awa, wd, awv, wv, bry} <= {a, v, 3'h7};
        // Wait as long as it takes; only the watchdog ends a hung beat
        do
        begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wry) wv <= 1'b0;
            if (bv) {b, bry} <= {br, 1'b0};
        end while (bry);
    endtask : wr
    // Read beat; data and response taken at the rvalid edge
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        {ara, arv, rry} <= {a, 2'h3};
        do
        begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            if (rv) {d, r, rry} <= {rdat, rr, 1'b0};
        end while (rry);
    endtask : rd
    // Select a log entry, then read one of its fields
    task automatic ent(input logic [5:0] x, input logic [7:0] o, input logic [31:0] e);
        wr(`ALB_INDEX_OFS, {26'h0, x});
        rd(o);
        chk(d, e);
    endtask : ent
    // One-cycle alarm event; gone stamps a fixed ms so removal is recognisable
    task automatic ev(input logic g, input logic [15:0] a, input logic [15:0] dy);
        @(posedge aclk);
        {rise, gone, c, fx, fl, days} <= {~g, g, a, ~{16'h0, a}, {a, 16'h3F80}, dy};
        ms <= g ? 32'h0000ABCD : {16'h0001, a};
        @(posedge aclk);
        {rise, gone} <= 2'h0;
    endtask : ev
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the few hundred bus beats of the run
    initial
    begin
        #40000;
        fail_count++;
        wrap_up();
    end
    // Main sequence: reset, eight table rows, then overflow and flush cases
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ALB_CNT_OFS);
        chk(d, `ALB_CNT_RST);
        chk({16'h0, stat}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            k = 16'h0100 + 16'(i);
            rows[i] = '{k, ~{16'h0, k}, {k, 16'h3F80}, 32'(i + 1)};
            ev(1'b0, k, 16'h0010);
            rd(`ALB_CNT_OFS);
            chk(d, rows[i].n);
            chk({16'h0, lat}, {16'h0, rows[i].c});
            chk({16'h0, stat}, 32'h80);
            ent(i[5:0], `ALB_CODE_OFS, {16'h0, rows[i].c});
            ent(i[5:0], `ALB_FIXED_OFS, rows[i].fx);
            ent(i[5:0], `ALB_FLOAT_OFS, rows[i].fl);
            ent(i[5:0], `ALB_ARR_DAYS_OFS, 32'h10);
            ent(i[5:0], `ALB_ARR_MS_OFS, {16'h1, rows[i].c});
            ent(i[5:0], `ALB_REM_MS_OFS, 32'h0);
        end
        $display("test rows done");
        ev(1'b0, 16'h0199, 16'h0011);
        ent(6'h06, `ALB_CODE_OFS, 32'h199);
        ent(6'h07, `ALB_CODE_OFS, 32'h107);
        ev(1'b1, 16'h0100, 16'h0020);
        ent(6'h00, `ALB_REM_DAYS_OFS, 32'h20);
        ent(6'h00, `ALB_REM_MS_OFS, 32'hABCD);
        ent(6'h00, `ALB_FLAGS_OFS, 32'h3);
        $display("test overwrite done");
        ev(1'b0, 16'h0200, 16'h0021);
        ent(6'h08, `ALB_CODE_OFS, 32'h100);
        ent(6'h09, `ALB_FLAGS_OFS, 32'h0);
        ent(6'h00, `ALB_CODE_OFS, 32'h101);
        ent(6'h07, `ALB_CODE_OFS, 32'h200);
        ev(1'b1, 16'h0101, 16'h0022);
        ev(1'b1, 16'h0102, 16'h0022);
        ev(1'b1, 16'h0200, 16'h0022);
        wr(`ALB_CNT_OFS, 32'h0);
        ent(6'h08, `ALB_CODE_OFS, 32'h200);
        ent(6'h0A, `ALB_CODE_OFS, 32'h101);
        ent(6'h0B, `ALB_CODE_OFS, 32'h100);
        ent(6'h00, `ALB_CODE_OFS, 32'h103);
        $display("test flush done");
        for (int i = 3; i < 10; i++)
            ev(1'b1, (i == 8) ? 16'h0199 : 16'h0100 + 16'(i), 16'h0023);
        chk({16'h0, stat}, 32'h0);
        rd(8'h40);
        chk({30'h0, r}, {30'h0, `ALB_RESP_SLVERR});
        wr(8'h40, 32'h1);
        chk({30'h0, b}, {30'h0, `ALB_RESP_SLVERR});
        $display("test clear done");
        // 56 flushes fill the history, the first also taking five removed leftovers; alarm 0x300 ends at 63
        for (int i = 0; i < 56; i++)
        begin
            ev(1'b0, 16'h0300 + 16'(i), 16'h0030);
            ev(1'b1, 16'h0300 + 16'(i), 16'h0030);
            wr(`ALB_CNT_OFS, 32'h0);
        end
        ent(6'h3F, `ALB_CODE_OFS, 32'h300);
        ent(6'h08, `ALB_CODE_OFS, 32'h337);
        $display("test history full done");
        wrap_up();
    end
endmodule : alarm_log_buffer_bench
`default_nettype wire
